// File: rtl/gcm_pkg.sv
// Shared constants for the monitor channel command handler.
// Assumes one system clock; link timing is sampled, not clocked.
package gcm_pkg;
    // Monitor channel command bytes
    localparam logic [7:0] CMD_GND_KEY_WR = 8'hE8;
    localparam logic [7:0] CMD_GND_KEY_RD = 8'hE9;
    localparam logic [7:0] CMD_RT_RD = 8'h4D;
    localparam logic [7:0] CMD_RT_RD_CLR = 8'h4F;
    localparam logic [7:0] CMD_MASK_WR = 8'h6C;
    localparam logic [7:0] CMD_MASK_RD = 8'h6D;
    localparam logic [7:0] CMD_GAIN_WR = 8'h50;
    localparam logic [7:0] CMD_GAIN_RD = 8'h51;
    localparam logic [7:0] CMD_TXG_WR = 8'h80;
    localparam logic [7:0] CMD_TXG_RD = 8'h81;
    localparam int RW_BIT = 0;
    localparam int CLR_BIT = 1;
    localparam logic [3:0] MAX_DATA_BYTES = 4'hE;
    // Reset values
    localparam logic [3:0] GND_KEY_RST = 4'h0;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [15:0] TXG_RST = 16'hA9F0;
    // Analog gain byte fields
    localparam int ATT_DIS_BIT = 7;
    localparam int TX_GAIN_BIT = 6;
    localparam int RX_LOSS_BIT = 5;
    localparam int SCALE_MSB = 4;
    localparam logic signed [5:0] SCALE_OFFSET = 6'sh10;
    localparam logic [4:0] LOOPBACK_CODE = 5'h10;
    // Transmit gain fixed point, 16 fractional bits
    localparam logic signed [19:0] GAIN_ONE = 20'sh10000;
    localparam int DIGITS = 4;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int GND_KEY_UNIT_MS = 1;
    localparam int MS_CYCLES = GND_KEY_UNIT_MS * 1000 * CLK_MHZ;
    // Link frame layout, bits per frame and downstream valid flag slot
    localparam logic [4:0] FRAME_BITS = 5'h11;
    localparam logic [4:0] DN_VALID_IDX = 5'h08;
endpackage

// File: rtl/gcm_mon_if.sv
// Byte carrier between the link shifter and the command core.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface gcm_mon_if;
    logic rx_valid;
    logic rx_idle;
    logic [7:0] rx_byte;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic tx_taken;
    logic [7:0] ci_byte;
    modport link (output rx_valid, rx_idle, rx_byte, tx_taken,
                  input tx_valid, tx_byte, ci_byte);
    modport core (input rx_valid, rx_idle, rx_byte, tx_taken,
                  output tx_valid, tx_byte, ci_byte);
endinterface

// File: rtl/gcm_gnd_key_filter.sv
// Sampling filter for the odd real-time detector bits.
// Assumes tick_in is a one-cycle pulse per millisecond, same clock.
`timescale 1ns/100ps
module gcm_gnd_key_filter #(
    parameter int W = 4
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic tick_in,
    input wire logic [3:0] period_in,
    input wire logic [W-1:0] raw_in,
    output logic [W-1:0] filt_out
);
    logic [3:0] ticks;
    logic [W-1:0] last_sample;
    logic sample;

    // Period zero means no filtering: follow the input every clock
    assign sample = (period_in == 4'h0) || (tick_in && (ticks >= period_in - 4'h1));

    // Millisecond tick counter
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ticks <= 4'h0;
        end else if (sample) begin
            ticks <= 4'h0;
        end else if (tick_in) begin
            ticks <= ticks + 4'h1;
        end
    end

    // Two agreeing samples one period apart are needed to move the output
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            last_sample <= '0;
            filt_out <= '0;
        end else if (sample) begin
            last_sample <= raw_in;
            if (period_in == 4'h0) begin
                filt_out <= raw_in;
            end else begin
                filt_out <= (raw_in & last_sample) | (filt_out & (raw_in | last_sample));
            end
        end
    end
endmodule

// File: rtl/gcm_link.sv
// Serial link shifter: one monitor byte each way per frame plus C/I.
// Assumes link clock, frame sync and data are pins from outside.
`timescale 1ns/100ps
module gcm_link (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic dcl_in,
    input wire logic fsc_in,
    input wire logic dd_in,
    output logic du_out,
    output logic du_oe_out,
    gcm_mon_if.link mon
);
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic dcl_prev;
    logic rise;
    logic fall;
    logic [4:0] rx_idx;
    logic [4:0] cur_idx;
    logic [7:0] rx_sh;
    logic [16:0] up_word;
    logic [4:0] up_cnt;

    // Two-flop synchronisers; only the second stage is read
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
            dcl_prev <= 1'b0;
        end else begin
            pin_meta <= {dcl_in, fsc_in, dd_in};
            pin_sync <= pin_meta;
            dcl_prev <= pin_sync[2];
        end
    end

    assign rise = pin_sync[2] && !dcl_prev;
    assign fall = !pin_sync[2] && dcl_prev;
    assign cur_idx = pin_sync[1] ? 5'h00 : rx_idx;

    // Downstream: byte MSB first, then a flag saying the byte is present
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_idx <= 5'h1F;
            rx_sh <= 8'h00;
            mon.rx_valid <= 1'b0;
            mon.rx_idle <= 1'b0;
            mon.rx_byte <= 8'h00;
        end else begin
            mon.rx_valid <= 1'b0;
            mon.rx_idle <= 1'b0;
            if (rise) begin
                if (cur_idx != 5'h1F) begin
                    rx_idx <= cur_idx + 5'h01;
                end
                if (cur_idx < gcm_pkg::DN_VALID_IDX) begin
                    rx_sh <= {rx_sh[6:0], pin_sync[0]};
                end else if (cur_idx == gcm_pkg::DN_VALID_IDX) begin
                    mon.rx_valid <= pin_sync[0];
                    mon.rx_idle <= !pin_sync[0];
                    mon.rx_byte <= rx_sh;
                end
            end
        end
    end

    // Upstream lags one bit: bit k is driven after the rise that took bit k
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            up_word <= 17'h1FFFF;
            up_cnt <= 5'h00;
            mon.tx_taken <= 1'b0;
            du_out <= 1'b1;
            du_oe_out <= 1'b0;
        end else begin
            mon.tx_taken <= 1'b0;
            if (rise && pin_sync[1]) begin
                up_word <= {mon.tx_valid ? mon.tx_byte : 8'hFF, mon.tx_valid, mon.ci_byte};
                up_cnt <= gcm_pkg::FRAME_BITS;
                mon.tx_taken <= mon.tx_valid;
            end else if (fall) begin
                if (up_cnt != 5'h00) begin
                    du_out <= up_word[16];
                    du_oe_out <= 1'b1;
                    up_word <= {up_word[15:0], 1'b1};
                    up_cnt <= up_cnt - 5'h01;
                end else begin
                    du_out <= 1'b1;
                    du_oe_out <= 1'b0;
                end
            end
        end
    end
endmodule

// File: rtl/gcm_monitor_top.sv
// Monitor channel command handler: decodes command and data bytes,
// holds the settings registers, real-time data and interrupt.
// Assumes link pins and detector pins are asynchronous to ref_clk_in.
//
// Overview of operation
// - E8h writes, E9h reads ground key interval
// - Low nibble sets 0..15 ms sampling period
// - Reserved bits ignored on write, read zero
// - 4Dh reads real-time data, 4Fh also clears
// - Two bits per channel, channel one lowest
// - Real-time bits also sent in C/I field
// - 6Ch writes, 6Dh reads interrupt mask
// - Mask one blocks bit; resets to all ones
// - Masked changes never pull interrupt low
// - Command then up to 14 data bytes
// - Coefficient read sends two bytes
// - Upstream answer carries no command byte
// - 50h writes, 51h reads analog gain byte
// - Attenuator, 6 dB gain and loss bits
// - Scaling step equals code minus sixteen
// - Code 10000 selects full digital loopback
// - 80h writes, 81h reads two-byte coefficient
// - Sign bit zero plus, one minus
// - Gain is one plus nested signed shifts
// - Coefficient resets to A9F0h
// - E1 mode picks multiplexed hook bit
`timescale 1ns/100ps
module gcm_monitor_top #(
    parameter int MS_CYCLES = gcm_pkg::MS_CYCLES
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic dcl_in,
    input wire logic fsc_in,
    input wire logic dd_in,
    input wire logic [3:0] debounced_detector_bit_in,
    input wire logic [3:0] second_detector_input_in,
    input wire logic [3:0] multiplexed_hook_bit_in,
    input wire logic e1_mux_enable_in,
    output logic du_out,
    output logic du_oe_out,
    output logic int_b_out,
    output logic attenuator_on_out,
    output logic tx_gain_6db_out,
    output logic rx_loss_6db_out,
    output logic loopback_out,
    output logic signed [5:0] scaling_step_out,
    output logic signed [19:0] tx_gain_out
);
    typedef enum logic [1:0] {GCM_IDLE, GCM_DATA} gcm_state_t;

    gcm_mon_if mon ();
    gcm_state_t state;
    logic [12:0] det_meta;
    logic [12:0] det_sync;
    logic [3:0] odd_raw;
    logic [3:0] odd_filt;
    logic [7:0] rt_data;
    logic [7:0] rt_prev;
    logic [31:0] ms_cnt;
    logic ms_tick;
    logic [3:0] ground_key_interval;
    logic [7:0] detector_interrupt_mask;
    logic [7:0] analog_gain_scaling;
    logic [15:0] transmit_gain_coefficient;
    logic [7:0] cmd;
    logic [3:0] data_idx;
    logic cmd_go;
    logic wr_go;
    logic set_evt;
    logic clr_evt;
    logic pending;
    logic [7:0] resp0;
    logic [7:0] resp1;
    logic [1:0] resp_cnt;

    // Digits are evaluated innermost first: byte one high, low, byte two high, low
    function automatic logic signed [19:0] gcm_txg_eval(input logic [15:0] c);
        logic signed [19:0] x;
        logic signed [19:0] t;
        logic [3:0] d;
        x = gcm_pkg::GAIN_ONE;
        t = '0;
        d = 4'h0;
        for (int k = 0; k < gcm_pkg::DIGITS; k++) begin
            d = c[15 - 4 * k -: 4];
            t = x >>> d[2:0];
            x = d[3] ? gcm_pkg::GAIN_ONE - t : gcm_pkg::GAIN_ONE + t;
        end
        return x;
    endfunction

    gcm_link u_link (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .dcl_in(dcl_in),
        .fsc_in(fsc_in),
        .dd_in(dd_in),
        .du_out(du_out),
        .du_oe_out(du_oe_out),
        .mon(mon.link)
    );

    // Detector pins and the E1 strap pass two flops before any use
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            det_meta <= 13'h0000;
            det_sync <= 13'h0000;
        end else begin
            det_meta <= {e1_mux_enable_in, multiplexed_hook_bit_in,
                         second_detector_input_in, debounced_detector_bit_in};
            det_sync <= det_meta;
        end
    end

    // Odd bit source depends on E1 multiplexing
    assign odd_raw = det_sync[12] ? det_sync[11:8] : det_sync[7:4];

    // Millisecond timebase for the sampling filter
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ms_cnt <= 32'h0000_0000;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_cnt == 32'(MS_CYCLES - 1));
            ms_cnt <= (ms_cnt == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : ms_cnt + 32'h1;
        end
    end

    gcm_gnd_key_filter #(
        .W(4)
    ) u_filter (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .tick_in(ms_tick),
        .period_in(ground_key_interval),
        .raw_in(odd_raw),
        .filt_out(odd_filt)
    );

    // Pack real-time byte: even bit first detector, odd bit filtered second detector or, in E1 mode, hook bit
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rt_data <= 8'h00;
            rt_prev <= 8'h00;
        end else begin
            for (int i = 0; i < 4; i++) begin
                rt_data[2 * i] <= det_sync[i];
                rt_data[2 * i + 1] <= odd_filt[i];
            end
            rt_prev <= rt_data;
        end
    end

    // Same bits go upstream in the C/I field every frame
    assign mon.ci_byte = rt_data;

    // Byte strobes for command and data phases
    assign cmd_go = mon.rx_valid && (state == GCM_IDLE);
    assign wr_go = mon.rx_valid && (state == GCM_DATA)
                   && (data_idx < gcm_pkg::MAX_DATA_BYTES);

    // A new message starts only after a frame without a monitor byte
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= GCM_IDLE;
            cmd <= 8'h00;
            data_idx <= 4'h0;
        end else begin
            case (state)
                GCM_IDLE: begin
                    if (mon.rx_valid) begin
                        cmd <= mon.rx_byte;
                        data_idx <= 4'h0;
                        state <= GCM_DATA;
                    end
                end
                GCM_DATA: begin
                    if (mon.rx_idle) begin
                        state <= GCM_IDLE;
                    end else if (wr_go) begin
                        data_idx <= data_idx + 4'h1;
                    end
                end
                default: begin
                    state <= GCM_IDLE;
                end
            endcase
        end
    end

    // Ground key interval; upper nibble is dropped on write
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ground_key_interval <= gcm_pkg::GND_KEY_RST;
        end else if (wr_go && cmd == gcm_pkg::CMD_GND_KEY_WR && data_idx == 4'h0) begin
            ground_key_interval <= mon.rx_byte[3:0];
        end
    end

    // Interrupt mask, all bits masked out of reset
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            detector_interrupt_mask <= gcm_pkg::MASK_RST;
        end else if (wr_go && cmd == gcm_pkg::CMD_MASK_WR && data_idx == 4'h0) begin
            detector_interrupt_mask <= mon.rx_byte;
        end
    end

    // Analog gain and impedance scaling byte
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            analog_gain_scaling <= gcm_pkg::GAIN_RST;
        end else if (wr_go && cmd == gcm_pkg::CMD_GAIN_WR && data_idx == 4'h0) begin
            analog_gain_scaling <= mon.rx_byte;
        end
    end

    // Transmit gain coefficient, high byte first; extra bytes are ignored
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            transmit_gain_coefficient <= gcm_pkg::TXG_RST;
        end else if (wr_go && cmd == gcm_pkg::CMD_TXG_WR) begin
            if (data_idx == 4'h0) begin
                transmit_gain_coefficient[15:8] <= mon.rx_byte;
            end else if (data_idx == 4'h1) begin
                transmit_gain_coefficient[7:0] <= mon.rx_byte;
            end
        end
    end

    // Analog controls; code 10000 gives step zero and loopback together
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            attenuator_on_out <= 1'b1;
            tx_gain_6db_out <= 1'b0;
            rx_loss_6db_out <= 1'b0;
            loopback_out <= 1'b0;
            scaling_step_out <= -gcm_pkg::SCALE_OFFSET;
            tx_gain_out <= gcm_pkg::GAIN_ONE;
        end else begin
            attenuator_on_out <= !analog_gain_scaling[gcm_pkg::ATT_DIS_BIT];
            tx_gain_6db_out <= analog_gain_scaling[gcm_pkg::TX_GAIN_BIT];
            rx_loss_6db_out <= analog_gain_scaling[gcm_pkg::RX_LOSS_BIT];
            loopback_out <= analog_gain_scaling[gcm_pkg::SCALE_MSB:0]
                            == gcm_pkg::LOOPBACK_CODE;
            scaling_step_out <= $signed({1'b0, analog_gain_scaling[gcm_pkg::SCALE_MSB:0]})
                                - gcm_pkg::SCALE_OFFSET;
            tx_gain_out <= gcm_txg_eval(transmit_gain_coefficient);
        end
    end

    // Interrupt events: only unmasked changes count
    assign set_evt = |((rt_data ^ rt_prev) & ~detector_interrupt_mask);
    assign clr_evt = cmd_go && mon.rx_byte[7:2] == gcm_pkg::CMD_RT_RD[7:2]
                     && mon.rx_byte[gcm_pkg::RW_BIT] && mon.rx_byte[gcm_pkg::CLR_BIT];

    // A change in the same cycle as the clearing read wins over the clear
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pending <= 1'b0;
            int_b_out <= 1'b1;
        end else begin
            if (set_evt) begin
                pending <= 1'b1;
            end else if (clr_evt) begin
                pending <= 1'b0;
            end
            int_b_out <= !pending;
        end
    end

    // Read answers are queued data bytes only, never an echoed command
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            resp0 <= 8'h00;
            resp1 <= 8'h00;
            resp_cnt <= 2'h0;
        end else if (cmd_go && mon.rx_byte[gcm_pkg::RW_BIT]) begin
            resp_cnt <= 2'h1;
            if (mon.rx_byte == gcm_pkg::CMD_GND_KEY_RD) begin
                resp0 <= {4'h0, ground_key_interval};
            end else if (mon.rx_byte == gcm_pkg::CMD_RT_RD
                         || mon.rx_byte == gcm_pkg::CMD_RT_RD_CLR) begin
                resp0 <= rt_data;
            end else if (mon.rx_byte == gcm_pkg::CMD_MASK_RD) begin
                resp0 <= detector_interrupt_mask;
            end else if (mon.rx_byte == gcm_pkg::CMD_GAIN_RD) begin
                resp0 <= analog_gain_scaling;
            end else if (mon.rx_byte == gcm_pkg::CMD_TXG_RD) begin
                resp0 <= transmit_gain_coefficient[15:8];
                resp1 <= transmit_gain_coefficient[7:0];
                resp_cnt <= 2'h2;
            end else begin
                resp_cnt <= 2'h0;
            end
        end else if (mon.tx_taken && resp_cnt != 2'h0) begin
            resp0 <= resp1;
            resp_cnt <= resp_cnt - 2'h1;
        end
    end

    assign mon.tx_valid = resp_cnt != 2'h0;
    assign mon.tx_byte = resp0;

    a_mask_reset: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $rose(rst_b_in) |-> detector_interrupt_mask == 8'hFF)
        else $error("mask not all ones after reset");
    a_masked_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $rose(pending) |-> $past(set_evt))
        else $error("interrupt raised without unmasked change");
    a_int_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        pending && !clr_evt |=> pending)
        else $error("interrupt dropped without clearing read");
    a_int_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        clr_evt && !set_evt |=> !pending ##1 int_b_out)
        else $error("clearing read left interrupt set");
    a_int_pin: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        set_evt |=> ##1 !int_b_out)
        else $error("interrupt pin not low after event");
    a_key_write: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        wr_go && cmd == 8'hE8 && data_idx == 4'h0
        |=> ground_key_interval == $past(mon.rx_byte[3:0]))
        else $error("ground key write lost");
    a_txg_value: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (transmit_gain_coefficient == 16'hA9F0)[*2] |-> tx_gain_out == 20'sh1FEC0)
        else $error("transmit gain wrong for A9F0");
    a_loopback: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        analog_gain_scaling[4:0] == 5'h10 |=> loopback_out && scaling_step_out == 6'sh00)
        else $error("loopback code not honoured");
    a_rt_answer: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        cmd_go && mon.rx_byte == 8'h4D |=> resp0 == $past(rt_data) && resp_cnt == 2'h1)
        else $error("real-time read answer wrong");
    a_txg_read: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        cmd_go && mon.rx_byte == 8'h81
        |=> resp_cnt == 2'h2 && resp1 == $past(transmit_gain_coefficient[7:0]))
        else $error("coefficient read not two bytes");
endmodule

// File: rtl/dummy_unused_never.sv
// Holds no logic; the block lives in the other design files.

// File: verif/gcm_link_host.sv
// Link controller model: sends monitor frames and collects replies.
// Assumes the device samples dcl with its own clock.
`timescale 1ns/100ps
module gcm_link_host (
    output logic dcl_out,
    output logic fsc_out,
    output logic dd_out,
    input wire logic du_in,
    output logic [16:0] up_out,
    output logic seen_out
);
    logic [16:0] dn;
    initial {dcl_out, fsc_out, dd_out, seen_out} = 4'h2;
    // Clock stands still between frames; dd inverts so stale data never looks valid
    task automatic frame(input logic [7:0] b, input logic flag);
        dn = {b, flag, 8'hFF};
        #2; // Keeps every pin change off the system clock's rising edge
        for (int k = 0; k < 17; k++) begin
            dd_out = dn[16-k];
            fsc_out = (k == 0);
            #62 dcl_out = 1'b1;
            if (k > 0) up_out[17-k] = du_in;
            #63 dcl_out = 1'b0;
        end
        #60 up_out[0] = du_in;
        dd_out = ~dd_out;
        fsc_out = 1'b0;
        seen_out = up_out[8];
        #3 seen_out = 1'b0;
    endtask
endmodule

// File: verif/gci_monitor_cmd_handler_tb_top.sv
// Bench for the monitor command handler over its serial link.
// Assumes gcm_link_host frames the link; detectors are driven here.
`timescale 1ns/100ps
module gci_monitor_cmd_handler_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, e1 = 1'b0;
    logic [3:0] deb = 4'h0, sec = 4'h0, mux = 4'h0;
    logic dcl, fsc, dd, du, oe, int_b, att, txg, rxl, lpb, seen;
    logic signed [5:0] step;
    logic signed [19:0] gx;
    logic [16:0] up;
    logic [7:0] g, ck;
    logic [15:0] cf[3] = '{16'h0000, 16'h8888, 16'hA9F0};
    logic [15:0] exp_q[$];
    int err_total = 0;
    int tests_run = 0;
    // 100 MHz system clock
    initial forever #5 clk = ~clk;
    gcm_monitor_top #(.MS_CYCLES(200)) u_dut (.ref_clk_in(clk), .rst_b_in(rst_b),
        .dcl_in(dcl), .fsc_in(fsc), .dd_in(dd), .debounced_detector_bit_in(deb),
        .second_detector_input_in(sec), .multiplexed_hook_bit_in(mux),
        .e1_mux_enable_in(e1), .du_out(du), .du_oe_out(oe), .int_b_out(int_b),
        .attenuator_on_out(att), .tx_gain_6db_out(txg), .rx_loss_6db_out(rxl),
        .loopback_out(lpb), .scaling_step_out(step), .tx_gain_out(gx));
    gcm_link_host u_host (.dcl_out(dcl), .fsc_out(fsc), .dd_out(dd), .du_in(du),
        .up_out(up), .seen_out(seen));
    task automatic stop_test;
        $display("checks %0d bad %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Command frame, data frames, then idle frames that carry any reply
    task automatic xfer(input logic [7:0] c, input logic [15:0] d, input int nd, nr);
        u_host.frame(c, 1'b1);
        for (int i = 0; i < nd; i++) u_host.frame(i ? d[7:0] : d[15:8], 1'b1);
        for (int i = 0; i <= nr; i++) u_host.frame(8'hFF, 1'b0);
        @(negedge clk);
    endtask
    // Notes reply bytes high first; the mask hides bits a reader must ignore
    task automatic rd(input logic [7:0] c, input logic [15:0] v, input int nr = 1,
                      input logic [7:0] m = 8'hFF);
        for (int i = nr; i > 0; i--) exp_q.push_back({m, 8'(v >> (8 * (i - 1)))});
        xfer(c, 16'h0000, 0, nr);
    endtask
    task automatic wint(input logic v);
        for (int i = 0; i < 60 && int_b !== v; i++) @(negedge clk);
        chk(int_b, v);
        if (int_b !== v) stop_test();
    endtask
    function automatic logic [7:0] rt();
        for (int i = 0; i < 4; i++) rt[2*i +: 2] = {e1 ? mux[i] : sec[i], deb[i]};
    endfunction
    function automatic logic [19:0] csd(input logic [15:0] c);
        real t = 1.0;
        for (int i = 3; i >= 0; i--) t = 1.0 + (c[4*i+3] ? -t : t) / (2.0 ** c[4*i +: 3]);
        return 20'($rtoi(t * 65536.0));
    endfunction
    // Each flagged reply is matched against the oldest note
    always @(posedge seen) begin
        logic [15:0] e;
        e = exp_q.size() ? exp_q.pop_front() : {8'hFF, ~up[16:9]};
        chk(up[16:9] & e[15:8], e[7:0] & e[15:8]);
    end
    // Main sequence
    initial begin
        void'($urandom(32'hFE58874C));
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (8) @(negedge clk);
        chk({du, oe, int_b, att, txg, rxl, lpb, step}, {7'h58, 6'h30});
        chk(gx, 20'h1FEC0);
        rd(8'h6D, 16'h00FF);
        rd(8'hE9, 16'h0000, 1, 8'h0F);
        rd(8'h81, 16'hA9F0, 2);
        $display("test reset");
        for (int i = 0; i < 4; i++) begin
            g = i ? 8'($urandom) : 8'h10;
            xfer(8'h50, {g, 8'h00}, 1, 0);
            chk({att, txg, rxl, lpb, step},
                {~g[7], g[6:5], g[4:0] == 5'h10, 6'({1'b0, g[4:0]} - 6'h10)});
            rd(8'h51, {8'h00, g});
        end
        $display("test gain");
        foreach (cf[i]) begin
            xfer(8'h80, cf[i], 2, 0);
            chk(gx, csd(cf[i]));
            rd(8'h81, cf[i], 2);
        end
        $display("test coefficient");
        xfer(8'h6C, 16'hFE00, 1, 0);
        sec[0] = 1'b1;
        repeat (60) @(negedge clk);
        chk(int_b, 1'b1);
        deb[0] = 1'b1;
        wint(1'b0);
        rd(8'h4D, rt());
        chk({up[7:0], int_b, oe}, {rt(), 2'b01});
        rd(8'h4F, rt());
        wint(1'b1);
        $display("test interrupt");
        e1 = 1'b1;
        mux = 4'($urandom);
        repeat (8) @(negedge clk);
        rd(8'h4D, rt());
        xfer(8'hE8, 16'h0300, 1, 0);
        rd(8'hE9, 16'h0003, 1, 8'h0F);
        ck = rt();
        mux[3] = ~mux[3];
        u_host.frame(8'hFF, 1'b0);
        chk(up[7:0], ck);
        repeat (1400) @(negedge clk);
        u_host.frame(8'hFF, 1'b0);
        chk(up[7:0], rt());
        $display("test filter");
        // A reset in mid-run must bring back the power-up settings
        xfer(8'h80, 16'h8888, 2, 0);
        rst_b = 1'b0;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (8) @(negedge clk);
        chk(gx, 20'h1FEC0);
        rd(8'h6D, 16'h00FF);
        rd(8'hE9, 16'h0000, 1, 8'h0F);
        $display("test reset again");
        chk(20'(exp_q.size()), 20'h00000);
        stop_test();
    end
endmodule
